//--- spee_defines.svh
// Constants for the serial EEPROM command front end
`ifndef SPEE_DEFINES_SVH
`define SPEE_DEFINES_SVH
`define SPEE_OP_LATCH_SET 8'h06
`define SPEE_OP_LATCH_CLR 8'h04
`define SPEE_OP_STAT_RD 8'h05
`define SPEE_OP_STAT_WR 8'h01
`define SPEE_OP_ARR_RD 8'h03
`define SPEE_OP_ARR_WR 8'h02
`define SPEE_OP_ID_RD 8'h83
`define SPEE_OP_ID_WR 8'h82
`define SPEE_ST_LOCK 7
`define SPEE_ST_BP_HI 3
`define SPEE_ST_BP_LO 2
`define SPEE_ST_WEL 1
`define SPEE_ST_BUSY 0
`define SPEE_LOCK_ADDR_BIT 10
`define SPEE_PAGE_BYTES 128
`define SPEE_MIN_WR_BYTES 3'h4
`define SPEE_MIN_SR_BYTES 3'h2
`define SPEE_TW_CYCLES 1000
`define SPEE_ID_BYTE0 8'hA5
`define SPEE_ID_BYTE1 8'h5A
`define SPEE_ID_BYTE2 8'h3C
`endif

//--- spee_pkg.sv
// Types shared by the serial EEPROM command front end
package spee_pkg;
  typedef enum logic [1:0] {SPEE_IDLE, SPEE_WALK, SPEE_WAIT, SPEE_DONE} spee_wr_state_type;
  typedef enum logic [1:0] {SPEE_TGT_ARRAY, SPEE_TGT_IDPAGE, SPEE_TGT_STATUS,
                            SPEE_TGT_FREEZE} spee_target_type;
endpackage

//--- spee_core.sv
// Serial EEPROM slave front end: command framing, status and write cycle
`timescale 1ns/10ps
`include "spee_defines.svh"
// Notes on behaviour
// - Sample on rising, drive on falling clock
// - Deselected and not writing means standby
// - Hold low with clock low pauses transfer
// - Hold release resumes without losing bit count
// - Deselect during hold abandons the transfer
// - Ignore selection until select seen high first
// - Write needs latch, whole bytes, data byte
// - Select rising mid-byte drops write command
// - Reads shift out data until deselect
// - Busy flag set through internal write cycle
// - Write commands refused without enable latch
// - Latch cleared at reset, clear, write end
// - Protect bits change only by status write
// - Protect code selects quarter, half or all
// - Lock bit zero keeps status writable
// - Lock bit with protect low freezes status
// - Status bits six to four read zero
// - Identification page of 128 bytes, codes first
// - Unknown opcode waits until deselect
// - Opcode encodings as the instruction table
// - Two address bytes, bit ten picks lock
// - Latch set alone sets latch at deselect
// - Output driven only during reads, else released
// - Status readable anytime, repeats while selected
module spee_core #(
  parameter int WRITE_CYCLE_CLKS = `SPEE_TW_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic HOLD_N_I,
  input wire logic WP_N_I,
  output logic SO_O,
  output logic SO_OE_N_O,
  output logic STANDBY_O,
  output logic [7:0] STATUS_O,
  output logic [15:0] MEM_RADDR_O,
  input wire logic [7:0] MEM_RDATA_I,
  output logic MEM_WE_O,
  output logic [15:0] MEM_WADDR_O,
  output logic [7:0] MEM_WDATA_O
);
  localparam int PB = `SPEE_PAGE_BYTES;
  localparam logic [7:0] ID_B0 = `SPEE_ID_BYTE0; // Arbitrary identification value
  localparam logic [7:0] ID_B1 = `SPEE_ID_BYTE1; // Arbitrary identification value
  localparam logic [7:0] ID_B2 = `SPEE_ID_BYTE2; // Arbitrary identification value

  // Link-side state (serial clock domain)
  logic fresh;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] shift_in;
  logic [7:0] op;
  logic ign;
  logic [15:0] addr;
  logic [6:0] wptr;
  logic [7:0] sr_data;
  logic [7:0] pbuf [PB];
  logic [PB-1:0] pmask;
  logic rd_active;
  logic [15:0] rd_addr;
  logic hold_seen;
  logic busy_l1;
  logic busy_l2;
  logic [7:0] stat_l1;
  logic [7:0] stat_l2;
  logic so_q;
  logic so_en;
  logic [7:0] out_sr;
  // System-side state
  logic cs_s1, cs_s2, cs_s3;
  logic hold_s1, hold_s2;
  logic sck_s1, sck_s2;
  logic wp_s1, wp_s2;
  logic fresh_s1, fresh_s2;
  logic [36:0] sum_s1, sum_s2;
  logic edge_seen;
  logic armed;
  logic hold_q;
  logic busy;
  logic enable_latch_flag;
  logic lock_bit;
  logic [1:0] bp;
  logic id_frozen;
  logic [7:0] idpage [PB];
  spee_pkg::spee_wr_state_type wr_state;
  spee_pkg::spee_target_type target;
  logic [6:0] walk_idx;
  logic [31:0] tw_cnt;
  logic [8:0] wr_page;
  logic [7:0] new_status;

  // Link combinational view of the current rising edge
  logic [2:0] cur_bits;
  logic [2:0] cur_bytes;
  logic [7:0] next_shift;
  logic byte_done;
  logic op_known;
  logic is_write_op;
  logic data_we;
  logic [7:0] src_byte;
  assign cur_bits = fresh ? 3'h0 : bit_cnt;
  assign cur_bytes = fresh ? 3'h0 : byte_cnt;
  assign next_shift = {shift_in[6:0], SI_I};
  assign byte_done = (cur_bits == 3'h7);
  always_comb
  begin
    case (next_shift)
      `SPEE_OP_LATCH_SET, `SPEE_OP_LATCH_CLR, `SPEE_OP_STAT_RD, `SPEE_OP_STAT_WR,
      `SPEE_OP_ARR_RD, `SPEE_OP_ARR_WR, `SPEE_OP_ID_RD, `SPEE_OP_ID_WR: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  end
  assign is_write_op = (op == `SPEE_OP_ARR_WR) || (op == `SPEE_OP_ID_WR);
  assign data_we = byte_done && !ign && is_write_op && (cur_bytes >= 3'h3) && !busy_l2;

  // Frame start marker; select high re-arms it, so a new frame restarts the count
  always_ff @(posedge SCK_I or posedge CS_N_I)
  begin
    if (CS_N_I)
      fresh <= 1'b1;
    else if (HOLD_N_I)
      fresh <= 1'b0;
  end

  // Hold sampled at each rising edge; a held edge is not decoded
  always_ff @(posedge SCK_I)
  begin
    hold_seen <= !HOLD_N_I;
    busy_l1 <= busy;
    busy_l2 <= busy_l1;
  end

  // Input shifter and command decode; state survives deselect for the system side
  always_ff @(posedge SCK_I)
  begin
    if (HOLD_N_I)
    begin
      shift_in <= next_shift;
      bit_cnt <= cur_bits + 3'h1;
      if (byte_done && cur_bytes != 3'h7)
        byte_cnt <= cur_bytes + 3'h1;
      else if (fresh)
        byte_cnt <= 3'h0;
      if (byte_done && cur_bytes == 3'h0)
      begin
        op <= next_shift;
        // Only status read and latch clear may proceed during a write cycle
        ign <= !op_known || (busy_l2 && next_shift != `SPEE_OP_STAT_RD &&
               next_shift != `SPEE_OP_LATCH_CLR);
      end
      if (byte_done && cur_bytes == 3'h1)
      begin
        addr[15:8] <= next_shift;
        sr_data <= next_shift;
      end
      if (byte_done && cur_bytes == 3'h2)
      begin
        addr[7:0] <= next_shift;
        wptr <= next_shift[6:0];
      end
      else if (data_we)
        wptr <= wptr + 7'h1; // Rolls within the page
    end
  end

  // Page buffer: later bytes overwrite, so only the last page's worth is kept
  genvar gi;
  generate
    for (gi = 0; gi < PB; gi++)
    begin : g_pbuf
      always_ff @(posedge SCK_I)
      begin
        if (HOLD_N_I)
        begin
          if (byte_done && cur_bytes == 3'h0)
            pmask[gi] <= 1'b0;
          else if (data_we && wptr == 7'(gi))
          begin
            pmask[gi] <= 1'b1;
            pbuf[gi] <= next_shift;
          end
        end
      end
    end
  endgenerate

  // Read address tracking; array and identification reads start once opcode and address are whole, status read once the opcode is
  always_ff @(posedge SCK_I)
  begin
    if (HOLD_N_I)
    begin
      // A read left over from the last frame must not drive during the next opcode
      if (fresh)
        rd_active <= 1'b0;
      else if (byte_done && cur_bytes == 3'h0)
        rd_active <= op_known && next_shift == `SPEE_OP_STAT_RD;
      else if (byte_done && cur_bytes == 3'h2 && !ign &&
               (op == `SPEE_OP_ARR_RD || op == `SPEE_OP_ID_RD))
      begin
        rd_active <= 1'b1;
        rd_addr <= {addr[15:8], next_shift};
      end
      else if (byte_done && rd_active)
        rd_addr <= rd_addr + 16'h0001; // Array read wraps at the top
    end
  end

  // Status snapshot moved into the link domain on falling edges
  always_ff @(negedge SCK_I)
  begin
    stat_l1 <= STATUS_O;
    stat_l2 <= stat_l1;
  end

  // Source byte; page contents and lock are static while a read may run
  always_comb
  begin
    if (op == `SPEE_OP_STAT_RD)
      src_byte = stat_l2;
    else if (op == `SPEE_OP_ARR_RD)
      src_byte = MEM_RDATA_I;
    else if (addr[`SPEE_LOCK_ADDR_BIT])
      src_byte = {7'h00, id_frozen};
    else
      src_byte = idpage[rd_addr[6:0]];
  end
  assign MEM_RADDR_O = rd_addr;

  // Output shifter on falling edges, MSB first; released at deselect
  always_ff @(negedge SCK_I or posedge CS_N_I)
  begin
    if (CS_N_I)
    begin
      so_en <= 1'b0;
      so_q <= 1'b0;
      out_sr <= 8'h00;
    end
    else if (rd_active && !fresh && !hold_seen && !ign)
    begin
      so_en <= 1'b1;
      if (bit_cnt == 3'h0)
      begin
        so_q <= src_byte[7];
        out_sr <= {src_byte[6:0], 1'b0};
      end
      else
      begin
        so_q <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end
  assign SO_O = so_q;
  assign SO_OE_N_O = !(so_en && !hold_q && armed);

  // Pin and link synchronisers into the system clock
  always_ff @(posedge MCLK_I)
  begin
    cs_s1 <= CS_N_I;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    hold_s1 <= HOLD_N_I;
    hold_s2 <= hold_s1;
    sck_s1 <= SCK_I;
    sck_s2 <= sck_s1;
    wp_s1 <= WP_N_I;
    wp_s2 <= wp_s1;
    fresh_s1 <= fresh;
    fresh_s2 <= fresh_s1;
    // Summary is stable since the last serial edge, long before select is seen high
    sum_s1 <= {op, ign, (bit_cnt == 3'h0), byte_cnt, addr, sr_data};
    sum_s2 <= sum_s1;
  end

  // Frame summary fields
  logic [7:0] f_op;
  logic f_ign;
  logic f_whole;
  logic [2:0] f_bytes;
  logic [15:0] f_addr;
  logic [7:0] f_srdata;
  logic frame_end;
  logic prot_hit;
  logic sr_locked;
  assign {f_op, f_ign, f_whole, f_bytes, f_addr, f_srdata} = sum_s2;
  assign frame_end = cs_s2 && !cs_s3 && armed && edge_seen && !hold_q;
  assign sr_locked = lock_bit && !wp_s2;
  always_comb
  begin
    case (bp)
      2'b01: prot_hit = (f_addr[15:14] == 2'b11);
      2'b10: prot_hit = f_addr[15];
      2'b11: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  end

  // Selection arms only after select seen high; hold tracked with clock low
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      armed <= 1'b0;
      hold_q <= 1'b0;
      edge_seen <= 1'b0;
    end
    else
    begin
      if (cs_s2)
        armed <= 1'b1;
      if (cs_s2)
        hold_q <= 1'b0;
      else if (!sck_s2)
        hold_q <= !hold_s2;
      // A frame counts only if the serial clock rose in it; select high re-arms the marker
      if (cs_s2 && !cs_s3)
        edge_seen <= 1'b0;
      else if (!fresh_s2)
        edge_seen <= 1'b1;
    end
  end

  // Command completion at deselect and self-timed write cycle
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      wr_state <= spee_pkg::SPEE_IDLE;
      target <= spee_pkg::SPEE_TGT_ARRAY;
      busy <= 1'b0;
      enable_latch_flag <= 1'b0;
      walk_idx <= 7'h00;
      tw_cnt <= 32'h0;
      wr_page <= 9'h000;
      new_status <= 8'h00;
    end
    else
    begin
      case (wr_state)
        spee_pkg::SPEE_IDLE:
        begin
          if (frame_end && !f_ign && f_whole)
          begin
            if (f_op == `SPEE_OP_LATCH_SET && f_bytes == 3'h1)
              enable_latch_flag <= 1'b1;
            else if (f_op == `SPEE_OP_LATCH_CLR && f_bytes == 3'h1)
              enable_latch_flag <= 1'b0;
            else if (enable_latch_flag && !busy)
            begin
              if (f_op == `SPEE_OP_STAT_WR && f_bytes >= `SPEE_MIN_SR_BYTES && !sr_locked)
              begin
                target <= spee_pkg::SPEE_TGT_STATUS;
                new_status <= f_srdata;
                busy <= 1'b1;
                wr_state <= spee_pkg::SPEE_WALK;
              end
              else if (f_op == `SPEE_OP_ARR_WR && f_bytes >= `SPEE_MIN_WR_BYTES && !prot_hit)
              begin
                target <= spee_pkg::SPEE_TGT_ARRAY;
                wr_page <= f_addr[15:7];
                busy <= 1'b1;
                wr_state <= spee_pkg::SPEE_WALK;
              end
              else if (f_op == `SPEE_OP_ID_WR && f_bytes >= `SPEE_MIN_WR_BYTES &&
                       bp != 2'b11 && !id_frozen)
              begin
                target <= f_addr[`SPEE_LOCK_ADDR_BIT] ? spee_pkg::SPEE_TGT_FREEZE
                          : spee_pkg::SPEE_TGT_IDPAGE;
                busy <= 1'b1;
                wr_state <= spee_pkg::SPEE_WALK;
              end
            end
          end
          walk_idx <= 7'h00;
        end
        spee_pkg::SPEE_WALK:
        begin
          if (frame_end && f_op == `SPEE_OP_LATCH_CLR && f_bytes == 3'h1 && f_whole)
            enable_latch_flag <= 1'b0;
          walk_idx <= walk_idx + 7'h1;
          tw_cnt <= 32'h0;
          if (walk_idx == 7'(PB - 1))
            wr_state <= spee_pkg::SPEE_WAIT;
        end
        spee_pkg::SPEE_WAIT:
        begin
          if (frame_end && f_op == `SPEE_OP_LATCH_CLR && f_bytes == 3'h1 && f_whole)
            enable_latch_flag <= 1'b0;
          tw_cnt <= tw_cnt + 32'h1;
          if (tw_cnt == 32'(WRITE_CYCLE_CLKS - 1))
            wr_state <= spee_pkg::SPEE_DONE;
        end
        spee_pkg::SPEE_DONE:
        begin
          busy <= 1'b0;
          enable_latch_flag <= 1'b0;
          wr_state <= spee_pkg::SPEE_IDLE;
        end
        default: wr_state <= spee_pkg::SPEE_IDLE;
      endcase
    end
  end

  // Non-volatile status fields, updated only at the end of a status write or a page freeze
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      lock_bit <= 1'b0;
      bp <= 2'b00;
      id_frozen <= 1'b0;
    end
    else if (wr_state == spee_pkg::SPEE_DONE)
    begin
      if (target == spee_pkg::SPEE_TGT_STATUS)
      begin
        lock_bit <= new_status[`SPEE_ST_LOCK];
        bp <= {new_status[`SPEE_ST_BP_HI], new_status[`SPEE_ST_BP_LO]};
      end
      if (target == spee_pkg::SPEE_TGT_FREEZE)
        id_frozen <= 1'b1;
    end
  end

  // Identification page; first three bytes carry the identification codes
  generate
    for (gi = 0; gi < PB; gi++)
    begin : g_idpage
      always_ff @(posedge MCLK_I)
      begin
        if (RESET_I)
          idpage[gi] <= (gi == 0) ? ID_B0 : (gi == 1) ? ID_B1 : (gi == 2) ? ID_B2 : 8'h00;
        else if (wr_state == spee_pkg::SPEE_WALK && target == spee_pkg::SPEE_TGT_IDPAGE &&
                 walk_idx == 7'(gi) && pmask[gi])
          idpage[gi] <= pbuf[gi];
      end
    end
  endgenerate

  // Array write port, one buffered byte per system cycle during the walk
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      MEM_WE_O <= 1'b0;
      MEM_WADDR_O <= 16'h0000;
      MEM_WDATA_O <= 8'h00;
    end
    else
    begin
      MEM_WE_O <= (wr_state == spee_pkg::SPEE_WALK) && (target == spee_pkg::SPEE_TGT_ARRAY) &&
                  pmask[walk_idx];
      MEM_WADDR_O <= {wr_page, walk_idx};
      MEM_WDATA_O <= pbuf[walk_idx];
    end
  end

  // Status view and standby; bits six to four are constant zero
  assign STATUS_O = {lock_bit, 3'b000, bp, enable_latch_flag, busy};
  assign STANDBY_O = cs_s2 && !busy;
endmodule // spee_core

//--- spee_sva.sv
// Port checker for the serial EEPROM front end
`timescale 1ns/10ps
module spee_sva #(
  parameter int WRITE_CYCLE_CLKS = 1000
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic HOLD_N_I,
  input wire logic SO_OE_N_O,
  input wire logic STANDBY_O,
  input wire logic [7:0] STATUS_O,
  input wire logic MEM_WE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  int busy_cnt;
  // Length of the busy run, so a cut-short write cycle is caught
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I || !STATUS_O[0])
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  // Relations between status, strobes and the serial pins
  zero_bits_a: assert property (STATUS_O[6:4] == 3'h0)
    else $error("status bits six to four not zero");
  standby_busy_a: assert property (STATUS_O[0] && $past(STATUS_O[0]) |-> !STANDBY_O)
    else $error("standby during write cycle");
  store_busy_a: assert property (MEM_WE_O |-> STATUS_O[0])
    else $error("array store outside write cycle");
  out_release_a: assert property (CS_N_I && $past(CS_N_I) |-> SO_OE_N_O)
    else $error("output driven while deselected");
  hold_quiet_a: assert property ((!HOLD_N_I && !SCK_I) [*6] |-> SO_OE_N_O)
    else $error("output driven during hold");
  latch_drop_a: assert property ($fell(STATUS_O[0]) |-> ##[0:2] !STATUS_O[1])
    else $error("enable latch kept after write cycle");
  prot_hold_a: assert property ($changed(STATUS_O[7:2]) |-> STATUS_O[0] || $past(STATUS_O[0]))
    else $error("protect bits changed outside status write");
  cycle_len_a: assert property ($fell(STATUS_O[0]) |-> busy_cnt >= WRITE_CYCLE_CLKS
    && busy_cnt <= 131 + WRITE_CYCLE_CLKS)
    else $error("write cycle length wrong");
  // Main scenarios reached
  wr_c: cover property (MEM_WE_O);
  rd_c: cover property (!SO_OE_N_O);
  busy_c: cover property ($fell(STATUS_O[0]));
endmodule // spee_sva

//--- spee_master.sv
// Bus master model that frames commands on the serial link
`timescale 1ns/10ps
module spee_master (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  input wire logic so_i
);
  logic cpol = 1'b0;
  // Select starts low so the power-up guard is exercised
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // Clock idles at the mode level and only runs inside frames
  task automatic open_frame(input logic mode);
    cpol = mode;
    sck_o = mode;
    #24 cs_n_o = 1'b0;
    #24;
  endtask
  // MSB first; input changes while clock low, output sampled on the rise
  task automatic shift(input logic [7:0] tx, input int nbits, input int hold_at,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sck_o = 1'b0;
      si_o = tx[i];
      #24;
      if (i == hold_at)
      begin
        hold_n_o = 1'b0;
        #48 si_o = ~si_o;
        sck_o = 1'b1; // Stray edge must be ignored while held
        #24 sck_o = 1'b0;
        si_o = tx[i];
        #24 hold_n_o = 1'b1;
        #24;
      end
      sck_o = 1'b1;
      rx[i] = so_i;
      #24;
    end
  endtask
  // Released data line shows the inverse so stale bits never pass
  task automatic close_frame();
    sck_o = cpol;
    #24 cs_n_o = 1'b1;
    si_o = ~si_o;
    #96;
  endtask
endmodule // spee_master

//--- tb.sv
// Testbench for the serial EEPROM front end
`timescale 1ns/10ps
`include "spee_defines.svh"
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic mode = 1'b0;
  int hold_at = -1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, standby, mem_we;
  logic [7:0] status, mem_wdata;
  logic [15:0] mem_raddr, mem_waddr;
  logic [7:0] mem [0:65535];
  int miscompares = 0;
  int checks_done = 0;
  always #2 mclk = ~mclk;
  spee_core #(.WRITE_CYCLE_CLKS(20)) dut (.MCLK_I(mclk), .RESET_I(rst), .SCK_I(sck),
    .CS_N_I(cs_n), .SI_I(si), .HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so),
    .SO_OE_N_O(so_oe_n), .STANDBY_O(standby), .STATUS_O(status), .MEM_RADDR_O(mem_raddr),
    .MEM_RDATA_I(mem[mem_raddr]), .MEM_WE_O(mem_we), .MEM_WADDR_O(mem_waddr),
    .MEM_WDATA_O(mem_wdata));
  // A released data line shows the inverse of its last bit, so a missing enable is caught
  spee_master bus (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .so_i(so_oe_n ? !so : so));
  // Array stand-in; erased cells read all ones
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge mclk) if (mem_we) mem[mem_waddr] <= mem_wdata;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for the write cycle; a hang ends the run
  task automatic settle();
    int n;
    n = 0;
    repeat (12) @(posedge mclk);
    while (status[0] !== 1'b0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 400)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  // One framed command; extra bits leave it off a byte boundary
  task automatic cmd(input logic [7:0] b[$], input int extra, output logic [7:0] last);
    bus.open_frame(mode);
    foreach (b[i]) bus.shift(b[i], 8, hold_at, last);
    if (extra > 0) bus.shift(8'hFF, extra, -1, last);
    bus.close_frame();
    settle();
  endtask
  task automatic t_power();
    logic [7:0] r;
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    chk("latch after power-up", 8'h00, status);
    chk("standby", 8'h01, {7'h00, standby});
    $display("test power-up done");
  endtask
  task automatic t_latch();
    logic [7:0] r;
    hold_at = 3;
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    hold_at = -1;
    chk("latch set over hold", 8'h02, status);
    mode = 1'b1;
    cmd({`SPEE_OP_STAT_RD, 8'h00, 8'h00}, 0, r);
    chk("status repeat", 8'h02, r);
    cmd({`SPEE_OP_LATCH_CLR}, 0, r);
    chk("latch clear", 8'h00, status);
    mode = 1'b0;
    $display("test latch done");
  endtask
  task automatic t_write();
    logic [7:0] r;
    cmd({`SPEE_OP_ARR_WR, 8'h12, 8'h34, 8'h11}, 0, r);
    chk("unlatched write", 8'hFF, mem[16'h1234]);
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_ARR_WR, 8'h12, 8'h34, 8'hA7}, 4, r);
    chk("torn write", 8'hFF, mem[16'h1234]);
    cmd({`SPEE_OP_ARR_WR, 8'h12, 8'h34, 8'hA7, 8'h3C}, 0, r);
    chk("byte 0", 8'hA7, mem[16'h1234]);
    chk("byte 1", 8'h3C, mem[16'h1235]);
    chk("latch after write", 8'h00, status);
    cmd({`SPEE_OP_ARR_RD, 8'h12, 8'h34, 8'h00, 8'h00}, 0, r);
    chk("read stream", 8'h3C, r);
    $display("test write done");
  endtask
  task automatic t_protect();
    logic [7:0] r;
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_STAT_WR, 8'hF6}, 0, r);
    chk("status write", 8'h84, status);
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_ARR_WR, 8'hC0, 8'h00, 8'h55}, 0, r);
    chk("top quarter", 8'hFF, mem[16'hC000]);
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_ARR_WR, 8'hBF, 8'hFF, 8'h55}, 0, r);
    chk("below quarter", 8'h55, mem[16'hBFFF]);
    @(posedge mclk) #1 wp_n = 1'b0;
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_STAT_WR, 8'h00}, 0, r);
    chk("locked status", 8'h84, status & 8'hFC);
    @(posedge mclk) #1 wp_n = 1'b1;
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_STAT_WR, 8'h00}, 0, r);
    chk("unlocked status", 8'h00, status);
    $display("test protect done");
  endtask
  task automatic t_idpage();
    logic [7:0] r;
    logic [7:0] ids [3] = '{`SPEE_ID_BYTE0, `SPEE_ID_BYTE1, `SPEE_ID_BYTE2};
    for (int i = 0; i < 3; i++)
    begin
      cmd({`SPEE_OP_ID_RD, 8'h00, 8'(i), 8'h00}, 0, r);
      chk("id byte", ids[i], r);
    end
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_ID_WR, 8'h00, 8'h05, 8'h9E}, 0, r);
    cmd({`SPEE_OP_ID_RD, 8'h00, 8'h05, 8'h00}, 0, r);
    chk("id write", 8'h9E, r);
    cmd({`SPEE_OP_ID_RD, 8'h04, 8'h00, 8'h00}, 0, r);
    chk("lock state", 8'h00, r);
    cmd({8'hFF, `SPEE_OP_LATCH_SET}, 0, r);
    chk("unknown opcode", 8'h00, status);
    // Freeze the page through the shared opcode with address bit ten set
    cmd({`SPEE_OP_LATCH_SET}, 0, r);
    cmd({`SPEE_OP_ID_WR, 8'h04, 8'h00, 8'h00}, 0, r);
    cmd({`SPEE_OP_ID_RD, 8'h04, 8'h00, 8'h00}, 0, r);
    chk("page frozen", 8'h01, r);
    $display("test idpage done");
  endtask
  // Reset, then the scenarios in order
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    t_power();
    t_latch();
    t_write();
    t_protect();
    t_idpage();
    print_verdict();
  end
endmodule // tb
bind spee_core spee_sva #(.WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS)) chk_i (.MCLK_I(MCLK_I),
  .RESET_I(RESET_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I), .HOLD_N_I(HOLD_N_I),
  .SO_OE_N_O(SO_OE_N_O), .STANDBY_O(STANDBY_O), .STATUS_O(STATUS_O), .MEM_WE_O(MEM_WE_O));
